// ==== rtl/dac_chain_pkg.sv ====
// Shared constants and command word layout for the serial chain port
package dac_chain_pkg;
    localparam int WORD_BITS = 16;
    localparam int ADDR_MSB = 13;
    localparam int ADDR_LSB = 11;
    localparam int CTRL_MSB = 10;
    localparam int CTRL_LSB = 8;
    localparam int DATA_MSB = 7;
    localparam int DATA_LSB = 0;
    localparam int FIFO_DEPTH = 16;
    localparam int CODE_STEPS = 256;
    localparam logic [2:0] CTRL_PASS_THROUGH = 3'h0;
    localparam logic [2:0] CTRL_SET_PHASE = 3'h3;
    localparam logic PHASE_FALLING = 1'h0;
    localparam logic PHASE_RISING = 1'h1;
    localparam logic DOUT_RESET = 1'h0;
    localparam logic [15:0] SHIFT_RESET = 16'h0000;

    typedef struct packed {
        logic [2:0] addr;
        logic [2:0] ctrl;
        logic [7:0] channel_code;
    } cmd_word_t;

    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic din;
    } serial_pins_t;

    localparam serial_pins_t PINS_IDLE = '{sclk: 1'h0, cs_n: 1'h1, din: 1'h0};
endpackage : dac_chain_pkg

// ==== rtl/octal_dac_serial_chain_port.sv ====
// Serial chain port of an eight-channel converter with command FIFO
`timescale 1ns/10ps

// First-word-fall-through queue: the head is visible whenever out_valid_o is high
module cmd_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 16
) (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign in_ready_o = (count != (AW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem[rd_ptr];

    // Storage has no reset: only entries behind the count are ever read
    always_ff @(posedge mclk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'h1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'h1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : cmd_fifo

////////////////////////////////////////////////////////////////////////////////

module octal_dac_serial_chain_port
    import dac_chain_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic din_i,
    output logic dout_o,
    output cmd_word_t cmd_o,
    output logic cmd_valid_o,
    input wire logic cmd_ready_i,
    output logic word_lost_o,
    output logic phase_rising_o
);
    serial_pins_t sync1;
    serial_pins_t sync2;
    serial_pins_t sync3;
    serial_pins_t pins;
    logic [WORD_BITS-1:0] shift;
    logic phase;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_rise;
    logic [2:0] ctrl;
    logic commit;
    logic fifo_ready;
    logic [13:0] fifo_out;

    // True when stages two and three agree on a level that the filtered copy
    // does not hold yet; used for every pin edge so all edges share one rule
    function automatic logic settles_to(
        input logic stage2,
        input logic stage3,
        input logic filtered,
        input logic level
    );
        return (stage2 == level) && (stage3 == level) && (filtered != level);
    endfunction : settles_to

    ////////////////////////////////////////////////////////////////////////////
    // Three-stage pin synchroniser; reset to the idle pin levels
    // so that no false clock or select edge follows reset
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sync1 <= PINS_IDLE;
            sync2 <= PINS_IDLE;
            sync3 <= PINS_IDLE;
        end else begin
            sync1 <= '{sclk: sclk_i, cs_n: cs_n_i, din: din_i};
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // Filtered pin levels: a change counts only once stages two and three agree,
    // so a pin caught mid-transition cannot yield a double edge
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pins <= PINS_IDLE;
        end else begin
            if (sync2.sclk == sync3.sclk) begin
                pins.sclk <= sync3.sclk;
            end
            if (sync2.cs_n == sync3.cs_n) begin
                pins.cs_n <= sync3.cs_n;
            end
            if (sync2.din == sync3.din) begin
                pins.din <= sync3.din;
            end
        end
    end

    // Clock edges are ignored while select is high
    assign sclk_rise = settles_to(sync2.sclk, sync3.sclk, pins.sclk, 1'h1) && !pins.cs_n;
    assign sclk_fall = settles_to(sync2.sclk, sync3.sclk, pins.sclk, 1'h0) && !pins.cs_n;
    assign cs_rise = settles_to(sync2.cs_n, sync3.cs_n, pins.cs_n, 1'h1);

    ////////////////////////////////////////////////////////////////////////////
    // Shift register, MSB first
    // Only the last sixteen bits before the select rise count; earlier ones fall out
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            shift <= SHIFT_RESET;
        end else if (sclk_rise) begin
            shift <= {shift[WORD_BITS-2:0], pins.din};
        end
    end

    // Output timing: falling mode shows the top bit half a cycle after the shift that brings it there
    // Rising mode takes the bit one stage early, so it leaves with the shift itself
    // A phase change takes effect from the next frame, as it only happens on a select rise
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            dout_o <= DOUT_RESET;
        end else if (phase == PHASE_FALLING && sclk_fall) begin
            dout_o <= shift[WORD_BITS-1];
        end else if (phase == PHASE_RISING && sclk_rise) begin
            dout_o <= shift[WORD_BITS-2];
        end
        // Held otherwise, including whenever select is high
    end

    ////////////////////////////////////////////////////////////////////////////
    // Commit on select rise
    // Select edge comes from the filtered copy, so a select caught mid-transition commits once
    assign ctrl = shift[CTRL_MSB:CTRL_LSB];
    assign commit = cs_rise && (ctrl != CTRL_PASS_THROUGH);

    // Phase words are queued as well: their load action still reaches the consumer
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            phase <= PHASE_FALLING;
        end else if (cs_rise && ctrl == CTRL_SET_PHASE) begin
            phase <= shift[ADDR_MSB] ? PHASE_RISING : PHASE_FALLING;
        end
    end

    // A word arriving with the queue full cannot stall the host, so it is flagged
    // The newest word is the one dropped; the consumer must keep up to avoid it
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            word_lost_o <= 1'h0;
        end else begin
            word_lost_o <= commit && !fifo_ready;
        end
    end

    // Channel code passes unchanged: straight binary, code over 256 of reference
    // Queue holds the word less its two don't-care bits
    cmd_fifo #(
        .WIDTH(14),
        .DEPTH(DEPTH)
    ) u_fifo (
        .mclk_i(mclk_i),
        .arst_n_i(arst_n_i),
        .in_data_i(shift[ADDR_MSB:DATA_LSB]),
        .in_valid_i(commit),
        .in_ready_o(fifo_ready),
        .out_data_o(fifo_out),
        .out_valid_o(cmd_valid_o),
        .out_ready_i(cmd_ready_i)
    );

    assign cmd_o = cmd_word_t'(fifo_out);
    // Phase is exported so the consumer knows which output timing is in force
    assign phase_rising_o = phase;
endmodule : octal_dac_serial_chain_port

// ==== bench/octal_dac_serial_chain_port_assertions.sv ====
// Checks on the chain port pins and command queue
`timescale 1ns/10ps
module octal_dac_serial_chain_port_assertions
    import dac_chain_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic din_i,
    input wire logic dout_o,
    input wire cmd_word_t cmd_o,
    input wire logic cmd_valid_o,
    input wire logic cmd_ready_i,
    input wire logic word_lost_o,
    input wire logic phase_rising_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!arst_n_i);
    a_dout_held_idle: assert property (cs_n_i [*6] |-> $stable(dout_o))
        else $error("dout moved while deselected");
    a_mode0_on_fall: assert property ($changed(dout_o) && !phase_rising_o |-> !sclk_i)
        else $error("dout moved off falling phase");
    a_mode1_on_rise: assert property ($changed(dout_o) && phase_rising_o |-> sclk_i)
        else $error("dout moved off rising phase");
    a_head_holds: assert property (cmd_valid_o && !cmd_ready_i |=> cmd_valid_o && $stable(cmd_o))
        else $error("queued word lost or changed");
    a_no_pass_queued: assert property (cmd_valid_o |-> cmd_o.ctrl != CTRL_PASS_THROUGH)
        else $error("pass-through word queued");
    a_push_on_commit: assert property ($rose(cmd_valid_o) |-> cs_n_i && $past(cs_n_i, 3))
        else $error("word queued without select rise");
    a_phase_on_commit: assert property ($changed(phase_rising_o) |-> cs_n_i ##[0:3] cmd_valid_o)
        else $error("phase changed outside commit");
    a_lost_pulse: assert property (word_lost_o |-> cmd_valid_o ##1 !word_lost_o)
        else $error("bad overflow pulse");
endmodule : octal_dac_serial_chain_port_assertions

bind octal_dac_serial_chain_port octal_dac_serial_chain_port_assertions #(.DEPTH(DEPTH)) chk (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i), .din_i(din_i),
    .dout_o(dout_o), .cmd_o(cmd_o), .cmd_valid_o(cmd_valid_o), .cmd_ready_i(cmd_ready_i),
    .word_lost_o(word_lost_o), .phase_rising_o(phase_rising_o));

// ==== bench/serial_host.sv ====
// Serial master model: clock idles low, toggles only in frames
`timescale 1ns/10ps
module serial_host (
    input wire logic mclk_i,
    input wire logic dout_i,
    output logic sclk_o,
    output logic cs_n_o,
    output logic din_o,
    output logic [15:0] rx_o
);
    initial begin
        sclk_o = 1'h0;
        cs_n_o = 1'h1;
        din_o = 1'h0;
        rx_o = 16'h0000;
    end
    // Two chained words; dout sampled late in the high phase to tell the phases apart
    task automatic frame(input logic [31:0] w);
        cs_n_o = 1'h0;
        for (int i = 31; i >= 0; i--) begin
            din_o = w[i];
            repeat (6) @(negedge mclk_i);
            sclk_o = 1'h1;
            repeat (6) @(negedge mclk_i);
            rx_o = {rx_o[14:0], dout_i};
            sclk_o = 1'h0;
        end
        repeat (6) @(negedge mclk_i);
        cs_n_o = 1'h1;
        din_o = ~din_o;
        repeat (12) @(negedge mclk_i);
    endtask : frame
endmodule : serial_host

// ==== bench/octal_dac_serial_chain_port_bench.sv ====
// Self-checking bench for the serial chain port
`timescale 1ns/10ps
module octal_dac_serial_chain_port_bench import dac_chain_pkg::*;;
    logic mclk = 1'h0;
    logic arst_n = 1'h0;
    logic cmd_ready = 1'h0;
    logic sclk, cs_n, din, dout, cmd_valid, word_lost, phase_rising;
    logic lost_seen = 1'h0;
    logic [15:0] rx;
    cmd_word_t cmd;
    int n_fail = 0;
    int n_compared = 0;
    int cycles = 0;
    initial begin
        forever #5 mclk = ~mclk;
    end
    serial_host host (.mclk_i(mclk), .dout_i(dout), .sclk_o(sclk), .cs_n_o(cs_n), .din_o(din),
        .rx_o(rx));
    octal_dac_serial_chain_port uut (.mclk_i(mclk), .arst_n_i(arst_n), .sclk_i(sclk),
        .cs_n_i(cs_n), .din_i(din), .dout_o(dout), .cmd_o(cmd), .cmd_valid_o(cmd_valid),
        .cmd_ready_i(cmd_ready), .word_lost_o(word_lost), .phase_rising_o(phase_rising));
    always @(posedge mclk) begin
        cycles++;
        if (word_lost === 1'h1) begin
            lost_seen = 1'h1;
        end
        if (cycles == 20000) begin
            n_fail++;
            finish_test();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic pop(input logic [13:0] exp);
        chk({1'h0, cmd_valid, cmd}, {2'h1, exp});
        cmd_ready = 1'h1;
        @(negedge mclk);
        cmd_ready = 1'h0;
        @(negedge mclk);
    endtask : pop
    task automatic t_pass;
        host.frame({16'h5A3C, 16'h38FF});
        chk(rx, 16'h5A3C);
        chk({15'h0000, cmd_valid}, 16'h0000);
    endtask : t_pass
    task automatic t_phase;
        host.frame({16'hFFFF, 16'h2300});
        chk({15'h0000, phase_rising}, 16'h0001);
        pop(14'h2300);
        host.frame({16'hC3A5, 16'h0000});
        chk(rx, 16'h874A);
        host.frame({16'h0000, 16'h0380});
        pop(14'h0380);
        chk({15'h0000, phase_rising}, 16'h0000);
        chk({15'h0000, lost_seen}, 16'h0000);
    endtask : t_phase
    task automatic t_fill;
        for (int i = 0; i < 17; i++) begin
            host.frame({16'hFFFF, 16'h2D00 + 16'(i)});
        end
        chk({15'h0000, lost_seen}, 16'h0001);
        for (int i = 0; i < 16; i++) begin
            pop(14'h2D00 + 14'(i));
        end
        chk({15'h0000, cmd_valid}, 16'h0000);
    endtask : t_fill
    task automatic finish_test;
        $display("Compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finish_test
    initial begin
        repeat (4) @(negedge mclk);
        arst_n = 1'h1;
        repeat (8) @(negedge mclk);
        t_pass();
        t_phase();
        t_fill();
        finish_test();
    end
endmodule : octal_dac_serial_chain_port_bench
